// File: verilog/bib_pkg.sv
// Constants shared by the bus information block register bank
package bib_pkg;
  // Byte offsets on the AHB-Lite register bus
  localparam logic [7:0] OFF_BUS_OPTIONS = 8'h20;
  localparam logic [7:0] OFF_UID_HIGH = 8'h24;
  localparam logic [7:0] OFF_UID_LOW = 8'h28;
  localparam logic [7:0] OFF_CONTROL = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  // Bus options field positions
  localparam int ISC_BIT = 29;
  localparam int BMC_BIT = 28;
  localparam int PMC_BIT = 27;
  localparam int ACC_LSB = 16;
  localparam int ACC_W = 8;
  localparam int MREQ_LSB = 12;
  localparam int MREQ_W = 4;
  localparam int GEN_LSB = 6;
  localparam int GEN_W = 2;
  localparam int SPD_LSB = 0;
  localparam int SPD_W = 3;
  // Reset and fixed values
  localparam logic [3:0] MREQ_RESET = 4'ha;
  localparam logic [3:0] MREQ_MIN = 4'h8;
  localparam logic [2:0] LINK_SPEED_CODE = 3'h2;
  localparam logic [31:0] UID_RESET = 32'h00000000;
  // Control register bits
  localparam int CTL_SOFT_RESET_BIT = 0;
  localparam int CTL_ROM_CHANGED_BIT = 1;
  localparam int CTL_BUS_RESET_BIT = 2;
  // Status register bits
  localparam int STS_LOCK_BIT = 0;
  localparam int STS_ROM_PEND_BIT = 1;
  localparam int STS_LOADER_BIT = 2;
  // Loader shifts the whole 64-bit identifier, one bit per serial bit
  localparam int UID_BITS = 64;
endpackage : bib_pkg

// File: verilog/bib_uid_loader.sv
// Serial loader: gathers the 64-bit identifier from the EEPROM bit stream
module bib_uid_loader #(
  parameter int UID_W = bib_pkg::UID_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic bit_valid,
  input wire logic bit_data,
  output logic busy,
  output logic done,
  output logic [UID_W-1:0] uid
);
  typedef enum logic [1:0] {BIB_IDLE, BIB_SHIFT, BIB_FIN} bib_load_e;
  bib_load_e state_q, state_d;
  logic [6:0] count_q;
  logic [UID_W-1:0] shift_q;
  wire last_bit = bit_valid && (count_q == 7'(UID_W - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      BIB_IDLE: if (start) state_d = BIB_SHIFT;
      BIB_SHIFT: if (last_bit) state_d = BIB_FIN;
      BIB_FIN: state_d = BIB_IDLE;
      default: state_d = BIB_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= BIB_IDLE;
      count_q <= 7'h00;
      shift_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == BIB_SHIFT && bit_valid) begin
        shift_q <= {shift_q[UID_W-2:0], bit_data};
        count_q <= count_q + 7'h01;
      end else if (state_q == BIB_IDLE) begin
        count_q <= 7'h00;
      end
    end
  end

  assign busy = (state_q == BIB_SHIFT);
  assign done = (state_q == BIB_FIN);
  assign uid = shift_q;
endmodule : bib_uid_loader

// File: verilog/bib_regs.sv
// Bus information block register bank behind an AHB-Lite slave
module bib_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic eeprom_present,
  input wire logic eeprom_bit_valid,
  input wire logic eeprom_bit_data,
  input wire logic bus_reset_evt,
  input wire logic link_on_bit,
  input wire logic [15:0] rx_block_len,
  input wire logic rx_block_write,
  output logic ack_type_error,
  output logic [63:0] unique_id,
  output logic uid_locked
);
  // Bus interface
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  wire access = hsel && hready && htrans[1];
  wire wr_now = wr_pend_q;
  wire rd_now = access && !hwrite;
  wire wr_opts = wr_now && (addr_q == bib_pkg::OFF_BUS_OPTIONS);
  wire wr_uhi = wr_now && (addr_q == bib_pkg::OFF_UID_HIGH);
  wire wr_ulo = wr_now && (addr_q == bib_pkg::OFF_UID_LOW);
  wire wr_ctl = wr_now && (addr_q == bib_pkg::OFF_CONTROL);

  // Register state
  logic isc_q, bmc_q, pmc_q;
  logic [7:0] acc_q;
  logic [3:0] mreq_q;
  logic [1:0] gen_q;
  logic [31:0] uid_hi_q, uid_lo_q;
  logic lock_q, hi_set_q, lo_set_q;
  logic rom_pend_q;
  logic load_started_q;
  logic ack_err_q;

  wire soft_reset = wr_ctl && hwdata[bib_pkg::CTL_SOFT_RESET_BIT];
  wire rom_changed = wr_ctl && hwdata[bib_pkg::CTL_ROM_CHANGED_BIT];
  wire sw_bus_reset = wr_ctl && hwdata[bib_pkg::CTL_BUS_RESET_BIT];
  wire bus_reset = bus_reset_evt || sw_bus_reset;

  // EEPROM loader
  logic ld_busy, ld_done;
  logic [63:0] ld_uid;
  wire ld_start = eeprom_present && !load_started_q && !lock_q;
  bib_uid_loader #(.UID_W(64)) u_loader (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(ld_start),
    .bit_valid(eeprom_bit_valid),
    .bit_data(eeprom_bit_data),
    .busy(ld_busy),
    .done(ld_done),
    .uid(ld_uid)
  );

  // Firmware may write each quadlet once when no EEPROM is present
  wire fw_hi = wr_uhi && !lock_q && !eeprom_present && !hi_set_q;
  wire fw_lo = wr_ulo && !lock_q && !eeprom_present && !lo_set_q;
  wire fw_done = (hi_set_q || fw_hi) && (lo_set_q || fw_lo);
  wire lock_set = ld_done || (fw_done && !lock_q && !eeprom_present);

  // Max request writes below 512 bytes are refused
  wire mreq_ok = hwdata[bib_pkg::MREQ_LSB +: bib_pkg::MREQ_W] >= bib_pkg::MREQ_MIN;

  // Largest block request in bytes
  // Code plus one is taken at five bits so that code Fh gives 64 KiB, not 1 byte
  wire [4:0] mreq_exp = {1'b0, mreq_q} + 5'h01;
  wire [16:0] max_bytes = 17'h00001 << mreq_exp;
  wire oversize = rx_block_write && ({1'b0, rx_block_len} > max_bytes);

  wire [31:0] opts_word = {2'b00, isc_q, bmc_q, pmc_q, 3'b000, acc_q, mreq_q, 4'h0,
                           gen_q, 3'b000, bib_pkg::LINK_SPEED_CODE};
  wire [31:0] ctl_word = {31'h0, 1'b0};
  wire [31:0] sts_word = {29'h0, ld_busy, rom_pend_q, lock_q};

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] opt,
                                           input logic [31:0] hi, input logic [31:0] lo,
                                           input logic [31:0] ctl, input logic [31:0] sts);
    case (a)
      bib_pkg::OFF_BUS_OPTIONS: read_mux = opt;
      bib_pkg::OFF_UID_HIGH: read_mux = hi;
      bib_pkg::OFF_UID_LOW: read_mux = lo;
      bib_pkg::OFF_CONTROL: read_mux = ctl;
      bib_pkg::OFF_STATUS: read_mux = sts;
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  wire [31:0] rd_value = read_mux(haddr, opts_word, uid_hi_q, uid_lo_q, ctl_word, sts_word);

  // AHB address and data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= access && hwrite;
      if (access) begin
        addr_q <= haddr;
      end
      if (rd_now) begin
        rdata_q <= rd_value;
      end
    end
  end

  // Bus management fields: cleared by hard or soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isc_q <= 1'b0;
      bmc_q <= 1'b0;
      pmc_q <= 1'b0;
      acc_q <= 8'h00;
      gen_q <= 2'h0;
    end else if (soft_reset) begin
      isc_q <= 1'b0;
      bmc_q <= 1'b0;
      pmc_q <= 1'b0;
      acc_q <= 8'h00;
      gen_q <= 2'h0;
    end else begin
      if (wr_opts) begin
        isc_q <= hwdata[bib_pkg::ISC_BIT];
        bmc_q <= hwdata[bib_pkg::BMC_BIT];
        pmc_q <= hwdata[bib_pkg::PMC_BIT];
        acc_q <= hwdata[bib_pkg::ACC_LSB +: bib_pkg::ACC_W];
      end
      if (bus_reset && (rom_pend_q || rom_changed)) begin
        gen_q <= gen_q + 2'h1;
      end else if (wr_opts) begin
        gen_q <= hwdata[bib_pkg::GEN_LSB +: bib_pkg::GEN_W];
      end
    end
  end

  // Max request survives soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mreq_q <= bib_pkg::MREQ_RESET;
    end else if (wr_opts && mreq_ok) begin
      mreq_q <= hwdata[bib_pkg::MREQ_LSB +: bib_pkg::MREQ_W];
    end
  end

  // Pending ROM change: a new change wins over the bus reset that consumes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_pend_q <= 1'b0;
    end else if (rom_changed) begin
      rom_pend_q <= 1'b1;
    end else if (bus_reset || soft_reset) begin
      rom_pend_q <= 1'b0;
    end
  end

  // Identifier storage: hard reset only, never soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uid_hi_q <= bib_pkg::UID_RESET;
      uid_lo_q <= bib_pkg::UID_RESET;
      hi_set_q <= 1'b0;
      lo_set_q <= 1'b0;
      lock_q <= 1'b0;
      load_started_q <= 1'b0;
    end else begin
      if (ld_start) begin
        load_started_q <= 1'b1;
      end
      if (ld_done && !lock_q) begin
        uid_hi_q <= ld_uid[63:32];
        uid_lo_q <= ld_uid[31:0];
      end else begin
        if (fw_hi) begin
          uid_hi_q <= hwdata;
          hi_set_q <= 1'b1;
        end
        if (fw_lo) begin
          uid_lo_q <= hwdata;
          lo_set_q <= 1'b1;
        end
      end
      if (lock_set) begin
        lock_q <= 1'b1;
      end
    end
  end

  // Acknowledge error for oversized block writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_err_q <= 1'b0;
    end else begin
      ack_err_q <= oversize;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ack_type_error = ack_err_q;
  assign unique_id = {uid_hi_q, uid_lo_q};
  assign uid_locked = lock_q;

  // Software must keep fields valid while the link is on; the block only guards max request
  wire link_guard_unused = link_on_bit;

  // Checks
  a_lock_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_q |=> lock_q) else $error("identifier lock dropped");
  a_uid_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_q |=> $stable(uid_hi_q) && $stable(uid_lo_q)) else $error("uid changed when locked");
  a_fw_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_uhi && lock_q) |=> $stable(uid_hi_q)) else $error("locked uid write took effect");
  a_mreq_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    mreq_q >= bib_pkg::MREQ_MIN) else $error("max request below 512 bytes");
  a_mreq_softrst: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_reset && !wr_opts) |=> $stable(mreq_q)) else $error("soft reset touched max request");
  a_gen_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus_reset && rom_pend_q && !soft_reset) |=> gen_q == $past(gen_q) + 2'h1)
    else $error("generation not stepped");
  a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    opts_word[26:24] == 3'h0 && opts_word[11:8] == 4'h0 && opts_word[5:3] == 3'h0)
    else $error("reserved bits nonzero");
  a_speed_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_now && haddr == bib_pkg::OFF_BUS_OPTIONS) |=> hrdata[2:0] == 3'h2)
    else $error("link speed wrong");
  a_isc_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_opts && !soft_reset) |=> isc_q == $past(hwdata[29]) && pmc_q == $past(hwdata[27]))
    else $error("flag write lost");
  a_ack_err: assert property (@(posedge hclk) disable iff (!hresetn)
    oversize |=> ack_type_error) else $error("oversize not flagged");
  c_eeprom_load: cover property (@(posedge hclk) disable iff (!hresetn) ld_done ##1 lock_q);
  c_fw_load: cover property (@(posedge hclk) disable iff (!hresetn) fw_hi ##[1:20] fw_lo);
  c_gen_step: cover property (@(posedge hclk) disable iff (!hresetn) rom_changed ##[1:20] bus_reset);
  c_oversize: cover property (@(posedge hclk) disable iff (!hresetn) oversize ##1 ack_type_error);
  c_soft_locked: cover property (@(posedge hclk) disable iff (!hresetn) soft_reset && lock_q);

  // Identifier storage checks
  a_lo_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ulo && lock_q) |=> $stable(uid_lo_q))
    else $error("locked low quadlet write took effect");

  a_fw_once_hi: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_uhi && hi_set_q && !ld_done) |=> $stable(uid_hi_q))
    else $error("second high quadlet write took effect");

  a_present_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_uhi && eeprom_present && !ld_done) |=> $stable(uid_hi_q))
    else $error("firmware write with eeprom took effect");

  a_uid_softrst: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_reset && !ld_done) |=> $stable(uid_hi_q) && $stable(uid_lo_q))
    else $error("soft reset touched identifier");

  a_lock_fw: assert property (@(posedge hclk) disable iff (!hresetn)
    (fw_done && !lock_q && !eeprom_present) |=> lock_q)
    else $error("firmware load did not lock");

  a_lock_eeprom: assert property (@(posedge hclk) disable iff (!hresetn)
    (ld_done && !lock_q) |=> lock_q && unique_id == $past(ld_uid))
    else $error("eeprom load did not land and lock");

  a_rdata_uid: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_now && haddr == bib_pkg::OFF_UID_HIGH) |=> hrdata == $past(uid_hi_q))
    else $error("high quadlet read wrong");

  // Bus options checks
  a_mreq_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_opts |=> $stable(mreq_q))
    else $error("max request changed without write");

  a_mreq_low_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_opts && !mreq_ok) |=> $stable(mreq_q))
    else $error("max request took a code below 512 bytes");

  a_soft_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_reset |=> !isc_q && !bmc_q && !pmc_q && acc_q == 8'h00)
    else $error("soft reset left a flag set");

  a_acc_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_opts && !soft_reset) |=> acc_q == $past(hwdata[23:16]))
    else $error("accuracy write lost");

  a_bmc_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_opts && !soft_reset) |=> bmc_q == $past(hwdata[28]))
    else $error("bus manager flag write lost");

  a_rom_pend_set: assert property (@(posedge hclk) disable iff (!hresetn)
    rom_changed |=> rom_pend_q)
    else $error("rom change not held pending");

  a_gen_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!bus_reset && !wr_opts && !soft_reset) |=> $stable(gen_q))
    else $error("generation moved without cause");

  a_rdata_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_now && haddr == bib_pkg::OFF_BUS_OPTIONS) |=>
      hrdata[26:24] == 3'h0 && hrdata[11:8] == 4'h0 && hrdata[5:3] == 3'h0)
    else $error("reserved bits read nonzero");

  // Bus side checks
  a_ack_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !oversize |=> !ack_type_error)
    else $error("type error without oversize block");

  a_rd_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_now |=> $stable(hrdata))
    else $error("read data changed outside a read");

  a_wr_phase: assert property (@(posedge hclk) disable iff (!hresetn)
    (access && hwrite) |=> wr_pend_q)
    else $error("write data phase not entered");
endmodule : bib_regs

// File: verif/bib_eeprom_model.sv
// Serial EEPROM stand-in that shifts out a 64-bit identifier
module bib_eeprom_model (
  input wire logic hclk,
  input wire logic fitted,
  input wire logic go,
  input wire logic [63:0] id,
  input wire logic [1:0] gap,
  output logic present,
  output logic bit_valid,
  output logic bit_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] sh_q = 64'h0;
  logic [6:0] left_q = 7'h0;
  logic [1:0] wait_q = 2'h0;
  logic cur_q = 1'b0;
  logic valid_q = 1'b0;
  assign present = fitted;
  assign bit_valid = valid_q;
  // Between bits the line shows the inverse of the last bit
  assign bit_data = valid_q ? cur_q : ~cur_q;
  always @(posedge hclk) begin
    valid_q <= 1'b0;
    if (go && left_q == 7'h0) begin
      sh_q <= id;
      left_q <= 7'h40;
      wait_q <= gap;
    end else if (left_q != 7'h0 && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (left_q != 7'h0) begin
      valid_q <= 1'b1;
      cur_q <= sh_q[63];
      sh_q <= {sh_q[62:0], 1'b0};
      left_q <= left_q - 7'h1;
      wait_q <= gap;
    end
  end
endmodule // bib_eeprom_model

// File: verif/bib_regs_bench.sv
// Self-checking bench for the bus information block register bank
module bib_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OPT = bib_pkg::OFF_BUS_OPTIONS;
  localparam logic [7:0] HI = bib_pkg::OFF_UID_HIGH;
  localparam logic [7:0] LO = bib_pkg::OFF_UID_LOW;
  localparam logic [7:0] CTL = bib_pkg::OFF_CONTROL;
  localparam logic [7:0] STS = bib_pkg::OFF_STATUS;
  localparam logic [63:0] EE_ID = 64'h0123_4567_89ab_cdef;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic ee_present, ee_valid, ee_data, bus_reset_evt, link_on_bit;
  logic rx_block_write, ack_type_error, uid_locked, fitted, go;
  logic [15:0] rx_block_len;
  logic [63:0] unique_id;
  int num_errors, total_checks;
  assign hready = hreadyout;
  bib_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eeprom_present(ee_present),
    .eeprom_bit_valid(ee_valid), .eeprom_bit_data(ee_data), .bus_reset_evt(bus_reset_evt),
    .link_on_bit(link_on_bit), .rx_block_len(rx_block_len), .rx_block_write(rx_block_write),
    .ack_type_error(ack_type_error), .unique_id(unique_id), .uid_locked(uid_locked));
  bib_eeprom_model ee (.hclk(hclk), .fitted(fitted), .go(go), .id(EE_ID), .gap(2'h1),
    .present(ee_present), .bit_valid(ee_valid), .bit_data(ee_data));
  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(what, {32'h0, exp}, {32'h0, rd});
    chk("response", 64'h0, {63'h0, hresp});
  endtask
  task automatic wchk(input logic [31:0] wd, input logic [31:0] exp);
    ahb(1'b1, OPT, wd);
    rchk("bus options", OPT, exp);
  endtask
  task automatic hard_reset();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic blk(input logic [15:0] len, input logic exp);
    rx_block_len <= len;
    rx_block_write <= 1'b1;
    @(posedge hclk);
    rx_block_write <= 1'b0;
    #1 chk("type error", {63'h0, exp}, {63'h0, ack_type_error});
    @(posedge hclk);
    #1 chk("type error end", 64'h0, {63'h0, ack_type_error});
    @(posedge hclk);
  endtask
  task automatic bus_reset();
    bus_reset_evt <= 1'b1;
    @(posedge hclk);
    bus_reset_evt <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic t_defaults();
    rchk("options", OPT, 32'h0000_a002);
    rchk("id high", HI, 32'h0);
    rchk("id low", LO, 32'h0);
    rchk("unmapped", 8'h44, 32'h0);
    chk("lock", 64'h0, {63'h0, uid_locked});
  endtask
  task automatic t_options();
    wchk(32'hffff_ffff, 32'h38ff_f0c2);
    wchk(32'h2000_8007, 32'h2000_8002);
    wchk(32'h1000_9000, 32'h1000_9002);
    wchk(32'h0800_a000, 32'h0800_a002);
    wchk(32'h00a5_b000, 32'h00a5_b002);
    wchk(32'h2000_7000, 32'h2000_b002);
    wchk(32'h0000_8000, 32'h0000_8002);
  endtask
  task automatic t_oversize();
    link_on_bit <= 1'b1;
    blk(16'd512, 1'b0);
    blk(16'd513, 1'b1);
    ahb(1'b1, OPT, 32'h0000_f000);
    blk(16'hffff, 1'b0);
    ahb(1'b1, OPT, 32'h0000_8000);
  endtask
  task automatic t_generation();
    ahb(1'b1, CTL, 32'h2);
    bus_reset();
    rchk("gen step", OPT, 32'h0000_8042);
    bus_reset();
    rchk("gen hold", OPT, 32'h0000_8042);
  endtask
  task automatic t_firmware();
    ahb(1'b1, OPT, 32'h38ff_9000);
    ahb(1'b1, HI, 32'h1234_5678);
    rchk("half lock", STS, 32'h0);
    ahb(1'b1, LO, 32'h9abc_def0);
    rchk("status", STS, 32'h1);
    chk("id", {32'h1234_5678, 32'h9abc_def0}, unique_id);
    ahb(1'b1, HI, 32'hffff_ffff);
    ahb(1'b1, CTL, 32'h1);
    rchk("id kept", HI, 32'h1234_5678);
    rchk("low kept", LO, 32'h9abc_def0);
    rchk("soft reset", OPT, 32'h0000_9002);
  endtask
  task automatic t_eeprom();
    int n;
    fitted <= 1'b1;
    hard_reset();
    ahb(1'b1, HI, 32'h5555_5555);
    rchk("id cleared", HI, 32'h0);
    rchk("options", OPT, 32'h0000_a002);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    n = 0;
    while (uid_locked !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (uid_locked !== 1'b1) begin
      num_errors++;
      close_out();
    end
    chk("loaded id", EE_ID, unique_id);
    ahb(1'b1, LO, 32'h0);
    rchk("low locked", LO, EE_ID[31:0]);
    rchk("high locked", HI, EE_ID[63:32]);
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    num_errors = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bus_reset_evt = 1'b0;
    link_on_bit = 1'b0;
    rx_block_len = 16'h0;
    rx_block_write = 1'b0;
    fitted = 1'b0;
    go = 1'b0;
    hard_reset();
    t_defaults();
    t_options();
    t_oversize();
    t_generation();
    t_firmware();
    t_eeprom();
    close_out();
  end
endmodule // bib_regs_bench
